//--- verif/port_host.sv
// Host model that drives the memory pins of one RAM port.
`timescale 1ns/1ns
module port_host #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 9
) (
  input  wire logic              clk_i,
  output logic      [ADDR_W-1:0] address_o,
  output logic                   address_strobe_n_o,
  output logic                   count_enable_n_o,
  output logic                   counter_reset_n_o,
  output logic                   chip_enable_low_active_o,
  output logic                   chip_enable_high_active_o,
  output logic                   read_write_n_o,
  output logic                   output_enable_n_o,
  output logic                   flow_through_select_o,
  output logic      [DATA_W-1:0] data_o
);
  initial begin
    address_o = '0;
    address_strobe_n_o = 1'b1;
    count_enable_n_o = 1'b1;
    counter_reset_n_o = 1'b1;
    chip_enable_low_active_o = 1'b1;
    chip_enable_high_active_o = 1'b0;
    read_write_n_o = 1'b1;
    output_enable_n_o = 1'b0;
    flow_through_select_o = 1'b0;
    data_o = 9'h0AA;
  end

  // One access per clock; ce is {low-active, high-active} as driven.
  // This host owns the only port, so no same-address collision arises.
  task automatic op(input logic ads_n, input logic cnt_n,
                    input logic crst_n, input logic [1:0] ce,
                    input logic rw, input logic [ADDR_W-1:0] adr,
                    input logic [DATA_W-1:0] dat);
    @(posedge clk_i);
    address_strobe_n_o <= ads_n;
    count_enable_n_o <= cnt_n;
    counter_reset_n_o <= crst_n;
    chip_enable_low_active_o <= ce[1];
    chip_enable_high_active_o <= ce[0];
    read_write_n_o <= rw;
    address_o <= adr;
    // Outside writes the bus shows the inverse of the last word, so data
    // latched at a wrong edge cannot pass for the right value.
    data_o <= rw ? ~data_o : dat;
  endtask

  task automatic set_mode(input logic pipe);
    flow_through_select_o <= pipe;
  endtask

  task automatic set_oe(input logic oe_n);
    output_enable_n_o <= oe_n;
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking testbench for one synchronous dual-port RAM port.
`timescale 1ns/1ns
module tb_top;
  import sdp_port_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic [13:0] address_i;
  logic        ads_n, cen_n, crst_n, cel, ceh, rw_n, oe_n, ftsel;
  logic [8:0]  din;
  logic [8:0]  data_io_o;
  logic        data_io_oe_n_o;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i, sel_nxt;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          n_mismatch, comparisons, cycles;
  localparam logic [1:0] S = 2'b01, XL = 2'b11, XH = 2'b00;

  sdp_ram_port i_sdp_ram_port (.clk_i(clk_i), .rst_i(rst_i),
    .address_i(address_i), .address_strobe_n_i(ads_n),
    .count_enable_n_i(cen_n), .counter_reset_n_i(crst_n),
    .chip_enable_low_active_i(cel), .chip_enable_high_active_i(ceh),
    .read_write_n_i(rw_n), .output_enable_n_i(oe_n),
    .flow_through_select_i(ftsel), .data_io_i(din),
    .data_io_o(data_io_o), .data_io_oe_n_o(data_io_oe_n_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  port_host i_port_host (.clk_i(clk_i), .address_o(address_i),
    .address_strobe_n_o(ads_n), .count_enable_n_o(cen_n),
    .counter_reset_n_o(crst_n), .chip_enable_low_active_o(cel),
    .chip_enable_high_active_o(ceh), .read_write_n_o(rw_n),
    .output_enable_n_o(oe_n), .flow_through_select_o(ftsel),
    .data_o(din));

  // ==========================================================================
  // Clock, timeout and checking
  // ==========================================================================
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Looks at the outputs mid-cycle, after the last edge has settled.
  task automatic look(string nm, logic exp_oe, logic [8:0] exp_d);
    @(negedge clk_i);
    check({nm, "_oe"}, 32'(data_io_oe_n_o), 32'(exp_oe));
    if (!exp_oe)
      check(nm, 32'(data_io_o), 32'(exp_d));
  endtask

  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel_nxt;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check("wb_ack", 32'(wb_ack_o), 32'h1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    sel_nxt = 4'hF;
    wb_dat_i = 32'h0;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    check("rst_oe", 32'(data_io_oe_n_o), 32'h1);
    wb(1'b0, CTRL_OFS, 32'h0, rd);
    check("ctrl_rst", rd, CTRL_RST);
    // Writes: load, increment, then a reset that still writes location 0.
    i_port_host.op(0, 1, 1, S, 0, 14'h0005, 9'h1A5);
    i_port_host.op(1, 0, 1, S, 0, 14'h0000, 9'h05A);
    i_port_host.op(1, 0, 0, S, 0, 14'h0123, 9'h0F0);
    // Flow-through reads back to back.
    i_port_host.op(0, 1, 1, S, 1, 14'h0005, 9'h000);
    i_port_host.op(1, 0, 1, S, 1, 14'h0000, 9'h000);
    look("rd5", 0, 9'h1A5);
    i_port_host.op(1, 1, 1, S, 1, 14'h0000, 9'h000);
    look("rd6", 0, 9'h05A);
    i_port_host.op(0, 0, 0, S, 1, 14'h0007, 9'h000);
    look("hold6", 0, 9'h05A);
    i_port_host.op(1, 1, 1, S, 1, 14'h0000, 9'h000);
    look("rst0", 0, 9'h0F0);
    i_port_host.op(0, 1, 1, XL, 1, 14'h0006, 9'h000);
    look("hold0", 0, 9'h0F0);
    i_port_host.op(1, 1, 1, XH, 0, 14'h0000, 9'h111);
    look("desel_l", 1, 9'h000);
    i_port_host.op(1, 1, 1, S, 1, 14'h0000, 9'h000);
    look("desel_h", 1, 9'h000);
    i_port_host.op(1, 1, 1, S, 1, 14'h0000, 9'h000);
    look("ld_desel", 0, 9'h05A);
    // Output enable acts between edges.
    i_port_host.set_oe(1'b1);
    #5;
    check("oe_off", 32'(data_io_oe_n_o), 32'h1);
    i_port_host.set_oe(1'b0);
    #5;
    check("oe_on", 32'(data_io_oe_n_o), 32'h0);
    // Pipelined: read data and deselection both land one edge later.
    i_port_host.op(1, 1, 1, XL, 1, 14'h0000, 9'h000);
    i_port_host.set_mode(1'b1);
    i_port_host.op(0, 1, 1, S, 1, 14'h0005, 9'h000);
    i_port_host.op(1, 1, 1, XL, 1, 14'h0000, 9'h000);
    look("pipe_wait", 1, 9'h000);
    i_port_host.op(1, 1, 1, XL, 1, 14'h0000, 9'h000);
    look("pipe_rd", 0, 9'h1A5);
    i_port_host.op(1, 1, 1, XL, 1, 14'h0000, 9'h000);
    look("pipe_off", 1, 9'h000);
    // Counter wraps from the top address to zero.
    i_port_host.op(0, 1, 1, XL, 1, 14'h3FFF, 9'h000);
    i_port_host.op(1, 0, 1, XL, 1, 14'h0000, 9'h000);
    i_port_host.op(1, 1, 1, XL, 1, 14'h0000, 9'h000);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    check("wrap", {18'h0, rd[13:0]}, 32'h0);
    check("mode_pipe", 32'(rd[STAT_MODE_BIT]), 32'h1);
    check("drv_off", 32'(rd[STAT_DRV_BIT]), 32'h0);
    // Register map: unmapped word, override to flow-through.
    wb(1'b0, 4'h8, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    wb(1'b1, CTRL_OFS, 32'h1, rd);
    wb(1'b0, CTRL_OFS, 32'h0, rd);
    check("ctrl", rd, 32'h1);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    check("mode_ovr", 32'(rd[STAT_MODE_BIT]), 32'h0);
    // A control write without the low byte lane is ignored.
    sel_nxt = 4'hE;
    wb(1'b1, CTRL_OFS, 32'h0, rd);
    sel_nxt = 4'hF;
    wb(1'b0, CTRL_OFS, 32'h0, rd);
    check("ctrl_sel", rd, 32'h1);
    end_sim();
  end
endmodule

//--- verilog/burst_counter.sv
// Burst address counter with reset, load, hold and increment.
`timescale 1ns/1ns
module burst_counter #(
  parameter int ADDR_W = 14
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] ext_addr_i,
  input  wire logic              address_strobe_n_i,
  input  wire logic              count_enable_n_i,
  input  wire logic              counter_reset_n_i,
  output logic      [ADDR_W-1:0] access_addr_o,
  output logic      [ADDR_W-1:0] count_o
);
  logic [ADDR_W-1:0] count_q;
  logic [ADDR_W-1:0] count_d;

  // ==========================================================================
  // Next address
  // ==========================================================================
  // The access address is the counter's new value, so reset and load
  // take effect in the same cycle without a dead slot.
  always_comb begin
    if (!counter_reset_n_i) begin
      count_d = '0;
    end else if (!address_strobe_n_i) begin
      count_d = ext_addr_i;
    end else if (!count_enable_n_i) begin
      count_d = count_q + ADDR_W'(1);
    end else begin
      count_d = count_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign access_addr_o = count_d;
  assign count_o       = count_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_reset_zero;
    @(posedge clk_i) disable iff (rst_i)
    !counter_reset_n_i |-> access_addr_o == '0 ##1 count_q == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Counter reset did not select address zero.");

  property p_load;
    @(posedge clk_i) disable iff (rst_i)
    counter_reset_n_i && !address_strobe_n_i
      |=> count_q == $past(ext_addr_i);
  endproperty
  a_load: assert property (p_load)
    else $error("Strobed address was not loaded into the counter.");

  property p_hold_inc;
    @(posedge clk_i) disable iff (rst_i)
    counter_reset_n_i && address_strobe_n_i
      |=> count_q == ($past(count_q)
                      + ADDR_W'($past(!count_enable_n_i)));
  endproperty
  a_hold_inc: assert property (p_hold_inc)
    else $error("Counter did not hold or advance by one.");

  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
    counter_reset_n_i && address_strobe_n_i && !count_enable_n_i
      && count_q == '1 |=> count_q == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Counter did not wrap to zero.");

  c_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
    count_q == '1 ##1 count_q == '0);
endmodule

//--- verilog/mem_port_if.sv
// Connection between the port control logic and the shared storage array.
`timescale 1ns/1ns
interface mem_port_if #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 9
);
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              we;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface

//--- verilog/ram_array.sv
// Storage array with one synchronous write and one combinational read port.
`timescale 1ns/1ns
module ram_array #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 9
) (
  input  wire logic   clk_i,
  mem_port_if.mem     port
);
  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] store [DEPTH];

  // A read of the word being written returns the old contents.
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  assign port.rdata = store[port.addr];
endmodule

//--- verilog/sdp_port_pkg.sv
// Shared constants and types for one synchronous dual-port RAM port.
package sdp_port_pkg;

  // ==========================================================================
  // Array geometry defaults
  // ==========================================================================
  localparam int ADDR_W_DEF = 14;
  localparam int DATA_W_DEF = 9;

  // ==========================================================================
  // Register map, byte addresses on the 32-bit bus
  // ==========================================================================
  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  STATUS_OFS    = 4'h4;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam int          CTRL_OVR_BIT  = 0;
  localparam int          CTRL_MODE_BIT = 1;
  localparam int          STAT_MODE_BIT = 16;
  localparam int          STAT_DRV_BIT  = 17;

  // ==========================================================================
  // Output modes
  // ==========================================================================
  typedef enum logic {
    MODE_FLOW = 1'b0,
    MODE_PIPE = 1'b1
  } out_mode_type;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic port_selected(input logic ce_low_active,
                                         input logic ce_high_active);
    return !ce_low_active && ce_high_active;
  endfunction

endpackage

//--- verilog/sdp_ram_port.sv
// One port of a synchronous dual-port RAM with burst counter and bus slave.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ns
module sdp_ram_port
  import sdp_port_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DATA_W = DATA_W_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] address_i,
  input  wire logic              address_strobe_n_i,
  input  wire logic              count_enable_n_i,
  input  wire logic              counter_reset_n_i,
  input  wire logic              chip_enable_low_active_i,
  input  wire logic              chip_enable_high_active_i,
  input  wire logic              read_write_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              flow_through_select_i,
  input  wire logic [DATA_W-1:0] data_io_i,
  output logic      [DATA_W-1:0] data_io_o,
  output logic                   data_io_oe_n_o,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o
);

  // ==========================================================================
  // Array and burst counter
  // ==========================================================================
  mem_port_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mem_bus ();

  logic [ADDR_W-1:0] access_addr;
  logic [ADDR_W-1:0] count;

  // The counter sees no chip enable at all, so bursts keep their place
  // while a bank is deselected.
  burst_counter #(.ADDR_W(ADDR_W)) u_counter (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .ext_addr_i         (address_i),
    .address_strobe_n_i (address_strobe_n_i),
    .count_enable_n_i   (count_enable_n_i),
    .counter_reset_n_i  (counter_reset_n_i),
    .access_addr_o      (access_addr),
    .count_o            (count)
  );

  ram_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_array (
    .clk_i (clk_i),
    .port  (mem_bus.mem)
  );

  logic selected;
  logic read_now;
  logic write_now;

  assign selected  = port_selected(chip_enable_low_active_i,
                                   chip_enable_high_active_i);
  assign read_now  = selected && read_write_n_i;
  assign write_now = selected && !read_write_n_i;

  assign mem_bus.addr  = access_addr;
  assign mem_bus.wdata = data_io_i;
  assign mem_bus.we    = write_now;

  // ==========================================================================
  // Mode selection
  // ==========================================================================
  logic [31:0]  ctrl_q;
  logic [31:0]  ctrl_d;
  out_mode_type mode;

  // Software may override the mode pin, which eases bring-up of a board
  // whose strap is fixed.
  always_comb begin
    if (ctrl_q[CTRL_OVR_BIT]) begin
      mode = out_mode_type'(ctrl_q[CTRL_MODE_BIT]);
    end else begin
      mode = out_mode_type'(flow_through_select_i);
    end
  end

  // ==========================================================================
  // Output path
  // ==========================================================================
  logic [DATA_W-1:0] stage_q;
  logic [DATA_W-1:0] stage_d;
  logic              stage_rd_q;
  logic              stage_rd_d;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic              drive_q;
  logic              drive_d;

  // The extra stage always runs, so a mode change mid-stream costs no
  // more than the latency difference itself.
  always_comb begin
    stage_d    = mem_bus.rdata;
    stage_rd_d = read_now;
    if (mode == MODE_PIPE) begin
      dout_d  = stage_q;
      drive_d = stage_rd_q;
    end else begin
      dout_d  = mem_bus.rdata;
      drive_d = read_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_q    <= '0;
      stage_rd_q <= 1'b0;
      dout_q     <= '0;
      drive_q    <= 1'b0;
    end else begin
      stage_q    <= stage_d;
      stage_rd_q <= stage_rd_d;
      dout_q     <= dout_d;
      drive_q    <= drive_d;
    end
  end

  assign data_io_o = dout_q;
  // Output enable bypasses the clock; this gate is the only logic after
  // the output flip-flops.
  assign data_io_oe_n_o = output_enable_n_i || !drive_q;

  // ==========================================================================
  // Register bus slave
  // ==========================================================================
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [31:0] status;
  logic        bus_req;

  assign bus_req = wb_cyc_i && wb_stb_i;

  always_comb begin
    status                = '0;
    status[ADDR_W-1:0]    = count;
    status[STAT_MODE_BIT] = (mode == MODE_PIPE);
    status[STAT_DRV_BIT]  = drive_q;
  end

  // Answers one cycle after the request; writes land on the acked edge.
  always_comb begin
    ack_d  = bus_req && !ack_q;
    rdat_d = rdat_q;
    ctrl_d = ctrl_q;
    if (ack_d) begin
      case (wb_adr_i)
        CTRL_OFS:   rdat_d = ctrl_q;
        STATUS_OFS: rdat_d = status;
        default:    rdat_d = '0;
      endcase
    end
    if (bus_req && ack_q && wb_we_i && wb_adr_i == CTRL_OFS
        && wb_sel_i[0]) begin
      ctrl_d       = '0;
      ctrl_d[1:0]  = wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
      ctrl_q <= CTRL_RST;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_addr_select;
    @(posedge clk_i) disable iff (rst_i)
    counter_reset_n_i |-> (!address_strobe_n_i ?
      mem_bus.addr == address_i :
      mem_bus.addr == count + ADDR_W'(!count_enable_n_i));
  endproperty
  a_addr_select: assert property (p_addr_select)
    else $error("Access address came from the wrong source.");

  property p_no_gap;
    @(posedge clk_i) disable iff (rst_i)
    !counter_reset_n_i && read_now && mode == MODE_FLOW
      |=> drive_q && data_io_o == $past(mem_bus.rdata);
  endproperty
  a_no_gap: assert property (p_no_gap)
    else $error("Read during counter reset lost its slot.");

  property p_reset_write;
    @(posedge clk_i) disable iff (rst_i)
    !counter_reset_n_i && write_now |-> mem_bus.we && mem_bus.addr == '0;
  endproperty
  a_reset_write: assert property (p_reset_write)
    else $error("Write during counter reset did not go to zero.");

  property p_deselect;
    @(posedge clk_i) disable iff (rst_i)
    (!selected || !read_write_n_i) && mode == MODE_FLOW |=> !drive_q;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("Outputs driven without a selected read.");

  property p_oe_off;
    @(posedge clk_i) disable iff (rst_i)
    output_enable_n_i |-> data_io_oe_n_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("Outputs driven while output enable is high.");

  property p_pipe_enable;
    @(posedge clk_i) disable iff (rst_i)
    mode == MODE_PIPE ##1 mode == MODE_PIPE
      |-> drive_q == $past(read_now, 2) ##0 1'b1;
  endproperty
  a_pipe_enable: assert property (p_pipe_enable)
    else $error("Pipelined enable did not lag by one clock.");

  property p_pipe_data;
    @(posedge clk_i) disable iff (rst_i)
    read_now && mode == MODE_PIPE ##1 mode == MODE_PIPE
      |=> drive_q && data_io_o == $past(mem_bus.rdata, 2);
  endproperty
  a_pipe_data: assert property (p_pipe_data)
    else $error("Pipelined read data not one clock late.");

  property p_counter_free;
    @(posedge clk_i) disable iff (rst_i)
    !selected && counter_reset_n_i && !address_strobe_n_i
      |=> count == $past(address_i);
  endproperty
  a_counter_free: assert property (p_counter_free)
    else $error("Counter stalled while the port was deselected.");

  property p_flow_data;
    @(posedge clk_i) disable iff (rst_i)
    read_now && mode == MODE_FLOW |=> data_io_o == $past(mem_bus.rdata);
  endproperty
  a_flow_data: assert property (p_flow_data)
    else $error("Flow-through read data did not match the array.");

  property p_pipe_off;
    @(posedge clk_i) disable iff (rst_i)
    !read_now && mode == MODE_PIPE ##1 mode == MODE_PIPE |=> !drive_q;
  endproperty
  a_pipe_off: assert property (p_pipe_off)
    else $error("Pipelined deselection did not lag by one clock.");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("Bus acknowledge stood for more than one cycle.");

  // A write without the low byte lane must leave the control word alone.
  property p_ctrl_sel;
    @(posedge clk_i) disable iff (rst_i)
    bus_req && ack_q && wb_we_i && !wb_sel_i[0]
      |=> ctrl_q == $past(ctrl_q);
  endproperty
  a_ctrl_sel: assert property (p_ctrl_sel)
    else $error("Control word changed without its byte enable.");

  c_flow_read: cover property (@(posedge clk_i) disable iff (rst_i)
    read_now && mode == MODE_FLOW ##1 drive_q);
  c_pipe_burst: cover property (@(posedge clk_i) disable iff (rst_i)
    read_now && !count_enable_n_i && address_strobe_n_i
    && mode == MODE_PIPE ##2 drive_q);
  c_reset_write: cover property (@(posedge clk_i) disable iff (rst_i)
    !counter_reset_n_i && write_now);
  c_bus_write: cover property (@(posedge clk_i) disable iff (rst_i)
    bus_req && ack_q && wb_we_i);
endmodule
